/* File: include/iosm_defines.svh */
`ifndef IOSM_DEFINES_SVH
`define IOSM_DEFINES_SVH
`define IOSM_N_SRC 25
`define IOSM_N_DST 18
`define IOSM_N_PG 4
`define IOSM_N_OD 4
`define IOSM_N_WORDS 33
// word indices; the byte offset is four times the index
`define IOSM_W_SRC_INV 18
`define IOSM_W_SRC_FRC 19
`define IOSM_W_MISC 20
`define IOSM_W_PG0 21
`define IOSM_PG_STRIDE 3
`define IOSM_PG_PRE 1
`define IOSM_PG_POST 2
`define IOSM_OFF_CTRL 12'h100
`define IOSM_OFF_STAT 12'h104
`define IOSM_D_SEL 4:0
`define IOSM_D_EN 8
`define IOSM_D_INV 9
`define IOSM_D_FRC 10
`define IOSM_PG_EN 0
`define IOSM_PG_SWM 1
`define IOSM_PG_LVL 2
`define IOSM_PG_STH 3
`define IOSM_PG_LOOPS 31:16
`define IOSM_M_OP 1:0
`define IOSM_M_PSC 2
`define IOSM_M_DEB 31:16
`define IOSM_C_SAVE 0
`define IOSM_C_RESTORE 1
`define IOSM_C_SWT 7:4
`define IOSM_S_BUSY 0
`define IOSM_S_LOADED 1
`define IOSM_S_PG 7:4
`define IOSM_CFG_RST 32'h0000_0000
`define IOSM_SRC_PG0 6
`define IOSM_SRC_PG1 7
`define IOSM_SRC_PG2 20
`define IOSM_SRC_PG3 21
`define IOSM_SRC_DEB 16
`define IOSM_SRC_PSC 17
`define IOSM_SRC_LOGIC 19
`define IOSM_SRC_INT 25'h03B_00C0
`define IOSM_DST_SEQ 7
`define IOSM_DST_DEB 8
`define IOSM_DST_PSC 9
`define IOSM_DST_LGA 10
`define IOSM_DST_LGB 11
`define IOSM_DST_PG0 13
`define IOSM_CLK_NS 4
`define IOSM_TICK_NS 15
`define IOSM_ACC_W 5
`endif

/* File: include/iosm_pkg.sv */
`default_nettype none
package iosm_pkg;
   typedef enum logic [1:0] {NV_IDLE, NV_LOAD, NV_SAVE} iosm_nv_state_t;
   typedef enum logic [1:0] {PG_IDLE, PG_PRE, PG_POST} iosm_pg_state_t;
   typedef enum logic [1:0] {LOP_AND, LOP_OR, LOP_XOR, LOP_XNOR} iosm_lop_t;
   typedef struct packed {
      logic [15:0] loops;
      logic start_high;
      logic level;
      logic sw_mode;
      logic en;
      logic [31:0] pre;
      logic [31:0] post;
   } iosm_pg_cfg_t;
endpackage : iosm_pkg
`default_nettype wire

/* File: src/iosm_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "iosm_defines.svh"

module iosm_pulse #(
   parameter int CNT_W = 32
) (
   // clock and control
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_tick,
   // triggers and setup
   input wire logic i_hw_trig,
   input wire logic i_sw_trig,
   input wire iosm_pkg::iosm_pg_cfg_t i_cfg,
   // pulse out
   output logic o_pulse
);
   iosm_pkg::iosm_pg_state_t st_q, st_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [15:0] loop_q, loop_d;
   logic out_q, out_d, hw_q, trig;
   logic pre_done, post_done, last_loop;

   assign pre_done = ({1'b0, cnt_q} + (CNT_W+1)'(1))
      >= {1'b0, i_cfg.pre[CNT_W-1:0]};
   assign post_done = ({1'b0, cnt_q} + (CNT_W+1)'(1))
      >= {1'b0, i_cfg.post[CNT_W-1:0]};
   assign last_loop = ({1'b0, loop_q} + 17'h1) >= {1'b0, i_cfg.loops};
   // edge mode compares with the previous sample of the line
   assign trig = i_cfg.en & (i_cfg.sw_mode ? i_sw_trig :
      (i_cfg.level ? i_hw_trig : i_hw_trig & ~hw_q));

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      loop_d = loop_q;
      out_d = out_q;
      case (st_q)
         iosm_pkg::PG_IDLE: begin
            out_d = i_cfg.start_high;
            if (trig) begin
               st_d = iosm_pkg::PG_PRE;
               cnt_d = '0;
               loop_d = 16'h0;
            end
         end
         iosm_pkg::PG_PRE: begin
            if (i_tick) begin
               if (pre_done) begin
                  st_d = iosm_pkg::PG_POST;
                  cnt_d = '0;
                  out_d = ~i_cfg.start_high;
               end else begin
                  cnt_d = cnt_q + CNT_W'(1);
               end
            end
         end
         iosm_pkg::PG_POST: begin
            if (i_tick) begin
               if (!post_done) begin
                  cnt_d = cnt_q + CNT_W'(1);
               end else if (last_loop) begin
                  st_d = iosm_pkg::PG_IDLE;
                  out_d = i_cfg.start_high;
               end else begin
                  st_d = iosm_pkg::PG_PRE;
                  loop_d = loop_q + 16'h1;
                  cnt_d = '0;
                  out_d = i_cfg.start_high;
               end
            end
         end
         default: st_d = iosm_pkg::PG_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_q <= iosm_pkg::PG_IDLE;
         cnt_q <= '0;
         loop_q <= 16'h0;
         out_q <= 1'b0;
         hw_q <= 1'b0;
      end else if (i_ce) begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         loop_q <= loop_d;
         out_q <= out_d;
         hw_q <= i_hw_trig;
      end
   end

   assign o_pulse = out_q;

   sequence s_sw_fire;
      i_ce && st_q == iosm_pkg::PG_IDLE && i_cfg.en && i_cfg.sw_mode
         && i_sw_trig;
   endsequence
   sequence s_pre_end;
      i_ce && st_q == iosm_pkg::PG_PRE && i_tick && pre_done;
   endsequence

   chk_pg_start_level: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && st_q == iosm_pkg::PG_IDLE) |=>
         o_pulse == $past(i_cfg.start_high))
      else $error("pulse idle level differs from start level");
   chk_pg_sw_trigger: assert property (
      @(posedge i_clk) disable iff (i_rst)
      s_sw_fire |=> st_q == iosm_pkg::PG_PRE)
      else $error("software trigger did not start pulse");
   chk_pg_edge_only: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && st_q == iosm_pkg::PG_IDLE && i_cfg.en && !i_cfg.sw_mode
         && !i_cfg.level && i_hw_trig && hw_q) |=>
         st_q == iosm_pkg::PG_IDLE)
      else $error("held line retriggered in edge mode");
   chk_pg_phase_flip: assert property (
      @(posedge i_clk) disable iff (i_rst)
      s_pre_end |=> st_q == iosm_pkg::PG_POST
         && o_pulse == !$past(i_cfg.start_high))
      else $error("pre phase end did not flip output");
endmodule : iosm_pulse

module iosm_top #(
   parameter int N_SRC = `IOSM_N_SRC,
   parameter int N_DST = `IOSM_N_DST,
   parameter int N_PG = `IOSM_N_PG,
   parameter int CNT_W = 32
) (
   // clock, reset, enable
   input wire logic I_CLOCK,
   input wire logic I_RST,
   input wire logic I_CLK_EN,
   // apb slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic O_PREADY,
   output logic [31:0] O_PRDATA,
   output logic O_PSLVERR,
   // matrix lines
   input wire logic [N_SRC-1:0] I_SRC_EXT,
   output logic [N_DST-1:0] O_DST,
   output logic [`IOSM_N_OD-1:0] O_OD_OUT,
   output logic [`IOSM_N_OD-1:0] O_OD_OE_N,
   // non-volatile memory port
   output logic O_NVM_REQ,
   output logic O_NVM_WE,
   output logic [5:0] O_NVM_ADDR,
   output logic [31:0] O_NVM_WDATA,
   input wire logic I_NVM_ACK,
   input wire logic [31:0] I_NVM_RDATA
);
   localparam int NW = `IOSM_N_WORDS;

   if (N_SRC != `IOSM_N_SRC || N_DST != `IOSM_N_DST ||
       N_PG != `IOSM_N_PG || CNT_W > 32 || CNT_W < 2) begin : g_bad
      $error("iosm_top: unsupported parameter values");
   end

   logic [31:0] cfg_q [NW];
   logic [31:0] cfg_d [NW];
   iosm_pkg::iosm_nv_state_t nv_q, nv_d;
   logic [5:0] idx_q, idx_d;
   logic loaded_q, loaded_d, nreq_q, nreq_d, nwe_q, nwe_d;
   logic [31:0] nwdata_q, nwdata_d, prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic [N_PG-1:0] swt_q, swt_d, pg_out;
   logic apb_setup, apb_acc, a_cfg, a_ctl, a_sts, aligned, busy;
   logic wr_ctl, do_restore, do_save;
   logic [9:0] a_idx;

   assign apb_setup = I_PSEL & ~I_PENABLE;
   assign apb_acc = I_PSEL & I_PENABLE & pready_q;
   assign a_idx = I_PADDR[11:2];
   assign aligned = I_PADDR[1:0] == 2'h0;
   assign a_cfg = aligned && a_idx < 10'(NW);
   assign a_ctl = I_PADDR == `IOSM_OFF_CTRL;
   assign a_sts = I_PADDR == `IOSM_OFF_STAT;
   assign busy = nv_q != iosm_pkg::NV_IDLE;
   assign wr_ctl = apb_acc & I_PWRITE & a_ctl & ~pslverr_q & ~busy;
   assign do_restore = wr_ctl & I_PWDATA[`IOSM_C_RESTORE];
   assign do_save = wr_ctl & I_PWDATA[`IOSM_C_SAVE] & ~do_restore;

   always_comb begin
      cfg_d = cfg_q;
      nv_d = nv_q;
      idx_d = idx_q;
      loaded_d = loaded_q;
      nreq_d = nreq_q;
      nwe_d = nwe_q;
      nwdata_d = nwdata_q;
      pready_d = 1'b0;
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      swt_d = '0;
      if (apb_setup) begin
         pready_d = 1'b1;
         prdata_d = 32'h0;
         // writes to the setup words are refused while the memory transfer owns the setup
         pslverr_d = !(a_cfg || a_ctl || a_sts) ||
            (I_PWRITE && (a_sts || (a_cfg && busy)));
         if (!I_PWRITE && a_cfg) begin
            prdata_d = cfg_q[a_idx[5:0]];
         end else if (!I_PWRITE && a_sts) begin
            prdata_d[`IOSM_S_BUSY] = busy;
            prdata_d[`IOSM_S_LOADED] = loaded_q;
            prdata_d[`IOSM_S_PG] = pg_out;
         end
      end
      if (apb_acc && I_PWRITE && !pslverr_q) begin
         if (a_cfg && !busy) begin
            cfg_d[a_idx[5:0]] = I_PWDATA;
         end
         if (a_ctl) begin
            swt_d = I_PWDATA[`IOSM_C_SWT];
         end
      end
      if (do_restore) begin
         for (int i = 0; i < NW; i++) begin
            cfg_d[i] = `IOSM_CFG_RST;
         end
      end else if (do_save) begin
         nv_d = iosm_pkg::NV_SAVE;
         idx_d = 6'h0;
         nreq_d = 1'b1;
         nwe_d = 1'b1;
         nwdata_d = cfg_q[0];
      end
      case (nv_q)
         iosm_pkg::NV_LOAD, iosm_pkg::NV_SAVE: begin
            if (I_NVM_ACK) begin
               if (nv_q == iosm_pkg::NV_LOAD) begin
                  cfg_d[idx_q] = I_NVM_RDATA;
               end
               if (idx_q == 6'(NW - 1)) begin
                  nv_d = iosm_pkg::NV_IDLE;
                  nreq_d = 1'b0;
                  nwe_d = 1'b0;
                  loaded_d = 1'b1;
               end else begin
                  idx_d = idx_q + 6'h1;
                  nwdata_d = cfg_q[idx_q + 6'h1];
               end
            end
         end
         default: ;
      endcase
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         for (int i = 0; i < NW; i++) begin
            cfg_q[i] <= `IOSM_CFG_RST;
         end
         nv_q <= iosm_pkg::NV_LOAD;
         idx_q <= 6'h0;
         loaded_q <= 1'b0;
         nreq_q <= 1'b1;
         nwe_q <= 1'b0;
         nwdata_q <= 32'h0;
         pready_q <= 1'b0;
         prdata_q <= 32'h0;
         pslverr_q <= 1'b0;
         swt_q <= '0;
      end else if (I_CLK_EN) begin
         cfg_q <= cfg_d;
         nv_q <= nv_d;
         idx_q <= idx_d;
         loaded_q <= loaded_d;
         nreq_q <= nreq_d;
         nwe_q <= nwe_d;
         nwdata_q <= nwdata_d;
         pready_q <= pready_d;
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
         swt_q <= swt_d;
      end
   end

   assign O_PREADY = pready_q;
   assign O_PRDATA = prdata_q;
   assign O_PSLVERR = pslverr_q;
   assign O_NVM_REQ = nreq_q;
   assign O_NVM_WE = nwe_q;
   assign O_NVM_ADDR = idx_q;
   assign O_NVM_WDATA = nwdata_q;

   // fractional tick: averages one tick per 15 ns on a 4 ns clock
   logic [`IOSM_ACC_W-1:0] acc_q, acc_d, acc_sum;
   logic tick_q, tick_d;
   assign acc_sum = acc_q + `IOSM_ACC_W'(`IOSM_CLK_NS);
   always_comb begin
      tick_d = acc_sum >= `IOSM_ACC_W'(`IOSM_TICK_NS);
      acc_d = tick_d ? acc_sum - `IOSM_ACC_W'(`IOSM_TICK_NS) : acc_sum;
   end

   // matrix with per-line inverter and force-high on both sides
   logic [N_SRC-1:0] src_raw, src;
   logic [N_DST-1:0] dst_q, dst_d;
   logic [`IOSM_N_OD-1:0] oe_n_q, oe_n_d;
   logic [31:0] dw;
   logic pick, deb_q, deb_d, psc_q, psc_d, lgc_q, lgc_d;
   always_comb begin
      src_raw = I_SRC_EXT & ~`IOSM_SRC_INT;
      src_raw[`IOSM_SRC_PG0] = pg_out[0];
      src_raw[`IOSM_SRC_PG1] = pg_out[1];
      src_raw[`IOSM_SRC_PG2] = pg_out[2];
      src_raw[`IOSM_SRC_PG3] = pg_out[3];
      src_raw[`IOSM_SRC_DEB] = deb_q;
      src_raw[`IOSM_SRC_PSC] = psc_q;
      src_raw[`IOSM_SRC_LOGIC] = lgc_q;
      src = (src_raw | cfg_q[`IOSM_W_SRC_FRC][N_SRC-1:0])
         ^ cfg_q[`IOSM_W_SRC_INV][N_SRC-1:0];
      dw = 32'h0;
      pick = 1'b0;
      dst_d = '0;
      for (int i = 0; i < N_DST; i++) begin
         dw = cfg_q[i];
         pick = dw[`IOSM_D_EN] && dw[`IOSM_D_SEL] < 5'(N_SRC) &&
            src[dw[`IOSM_D_SEL]];
         // force first, then invert: both set gives a steady low
         dst_d[i] = (pick | dw[`IOSM_D_FRC]) ^ dw[`IOSM_D_INV];
      end
      oe_n_d = ~{`IOSM_N_OD{loaded_q}} | dst_d[`IOSM_N_OD-1:0];
   end

   // function modules fed from registered destinations
   logic [15:0] dcnt_q, dcnt_d;
   logic pin_q, phase_q, phase_d;
   logic [31:0] mw;
   assign mw = cfg_q[`IOSM_W_MISC];
   always_comb begin
      deb_d = deb_q;
      dcnt_d = dcnt_q;
      if (dst_q[`IOSM_DST_DEB] == deb_q) begin
         dcnt_d = 16'h0;
      end else if (dcnt_q >= mw[`IOSM_M_DEB]) begin
         deb_d = dst_q[`IOSM_DST_DEB];
         dcnt_d = 16'h0;
      end else if (tick_q) begin
         dcnt_d = dcnt_q + 16'h1;
      end
      phase_d = phase_q ^ (pin_q & ~dst_q[`IOSM_DST_PSC]);
      psc_d = dst_q[`IOSM_DST_PSC] & ~(mw[`IOSM_M_PSC] & phase_q);
      case (iosm_pkg::iosm_lop_t'(mw[`IOSM_M_OP]))
         iosm_pkg::LOP_AND: lgc_d = dst_q[`IOSM_DST_LGA] & dst_q[`IOSM_DST_LGB];
         iosm_pkg::LOP_OR: lgc_d = dst_q[`IOSM_DST_LGA] | dst_q[`IOSM_DST_LGB];
         iosm_pkg::LOP_XOR: lgc_d = dst_q[`IOSM_DST_LGA] ^ dst_q[`IOSM_DST_LGB];
         default: lgc_d = ~(dst_q[`IOSM_DST_LGA] ^ dst_q[`IOSM_DST_LGB]);
      endcase
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         acc_q <= '0;
         tick_q <= 1'b0;
         dst_q <= '0;
         oe_n_q <= '1;
         deb_q <= 1'b0;
         dcnt_q <= 16'h0;
         pin_q <= 1'b0;
         phase_q <= 1'b0;
         psc_q <= 1'b0;
         lgc_q <= 1'b0;
      end else if (I_CLK_EN) begin
         acc_q <= acc_d;
         tick_q <= tick_d;
         dst_q <= dst_d;
         oe_n_q <= oe_n_d;
         deb_q <= deb_d;
         dcnt_q <= dcnt_d;
         pin_q <= dst_q[`IOSM_DST_PSC];
         phase_q <= phase_d;
         psc_q <= psc_d;
         lgc_q <= lgc_d;
      end
   end

   // open drain: the pin pulls low only, oe_n low while sinking
   assign O_DST = dst_q;
   assign O_OD_OUT = '0;
   assign O_OD_OE_N = oe_n_q;

   for (genvar g = 0; g < N_PG; g++) begin : g_pg
      iosm_pkg::iosm_pg_cfg_t c;
      logic [31:0] cw;
      assign cw = cfg_q[`IOSM_W_PG0 + `IOSM_PG_STRIDE * g];
      assign c.en = cw[`IOSM_PG_EN];
      assign c.sw_mode = cw[`IOSM_PG_SWM];
      assign c.level = cw[`IOSM_PG_LVL];
      assign c.start_high = cw[`IOSM_PG_STH];
      assign c.loops = cw[`IOSM_PG_LOOPS];
      assign c.pre = cfg_q[`IOSM_W_PG0 + `IOSM_PG_STRIDE * g + `IOSM_PG_PRE];
      assign c.post = cfg_q[`IOSM_W_PG0 + `IOSM_PG_STRIDE * g + `IOSM_PG_POST];
      iosm_pulse #(.CNT_W(CNT_W)) u_pg (
         .i_clk(I_CLOCK),
         .i_rst(I_RST),
         .i_ce(I_CLK_EN),
         .i_tick(tick_q),
         .i_hw_trig(dst_q[`IOSM_DST_PG0 + g]),
         .i_sw_trig(swt_q[g]),
         .i_cfg(c),
         .o_pulse(pg_out[g])
      );
   end

   for (genvar k = 0; k < N_DST; k++) begin : g_chk
      logic [31:0] w;
      logic sel_v;
      assign w = cfg_q[k];
      assign sel_v = (w[`IOSM_D_SEL] < 5'(N_SRC)) ? src[w[`IOSM_D_SEL]] : 1'b0;
      chk_force_low: assert property (
         @(posedge I_CLOCK) disable iff (I_RST)
         (I_CLK_EN && w[`IOSM_D_FRC] && w[`IOSM_D_INV]) |=> !dst_q[k])
         else $error("forced inverted line not low");
      chk_force_high: assert property (
         @(posedge I_CLOCK) disable iff (I_RST)
         (I_CLK_EN && w[`IOSM_D_FRC] && !w[`IOSM_D_INV]) |=> dst_q[k])
         else $error("forced line not high");
      chk_unrouted_idle: assert property (
         @(posedge I_CLOCK) disable iff (I_RST)
         (I_CLK_EN && !w[`IOSM_D_EN] && !w[`IOSM_D_FRC] && !w[`IOSM_D_INV])
            |=> !dst_q[k])
         else $error("unrouted line not inactive");
      chk_invert_pass: assert property (
         @(posedge I_CLOCK) disable iff (I_RST)
         (I_CLK_EN && w[`IOSM_D_EN] && w[`IOSM_D_INV] && !w[`IOSM_D_FRC]
            && w[`IOSM_D_SEL] < 5'(N_SRC)) |=> dst_q[k] == !$past(sel_v))
         else $error("inverted line not complement of source");
   end

   sequence s_last_load;
      I_CLK_EN && nv_q == iosm_pkg::NV_LOAD && I_NVM_ACK
         && idx_q == 6'(NW - 1);
   endsequence
   chk_od_released: assert property (
      @(posedge I_CLOCK) disable iff (I_RST)
      (I_CLK_EN && !loaded_q) |=> O_OD_OE_N == '1)
      else $error("open drain driven before setup loaded");
   chk_load_finish: assert property (
      @(posedge I_CLOCK) disable iff (I_RST)
      s_last_load |=> loaded_q && nv_q == iosm_pkg::NV_IDLE && !O_NVM_REQ)
      else $error("load did not finish on last word");
   chk_save_start: assert property (
      @(posedge I_CLOCK) disable iff (I_RST)
      (I_CLK_EN && do_save) |=> nv_q == iosm_pkg::NV_SAVE && O_NVM_REQ
         && O_NVM_WE && O_NVM_ADDR == 6'h0)
      else $error("save command did not start memory write");
   chk_restore_dflt: assert property (
      @(posedge I_CLOCK) disable iff (I_RST)
      (I_CLK_EN && do_restore) |=> cfg_q[0] == `IOSM_CFG_RST
         && cfg_q[NW-1] == `IOSM_CFG_RST)
      else $error("restore did not load defaults");
   chk_apb_answer: assert property (
      @(posedge I_CLOCK) disable iff (I_RST)
      (I_CLK_EN && apb_setup) |=> O_PREADY)
      else $error("apb access not answered in one cycle");
endmodule : iosm_top
`default_nettype wire

/* File: tb/iosm_nvm_model.sv */
`timescale 1ns/100ps
`default_nettype none
module iosm_nvm_model (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // memory port
   input wire logic i_req,
   input wire logic i_we,
   input wire logic [5:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wait,
   output logic o_ack,
   output logic [31:0] o_rdata
);
   logic [31:0] mem [0:63];
   logic [3:0] cnt_q;
   initial begin
      for (int i = 0; i < 64; i++) begin
         mem[i] = 32'h0000_0000;
      end
      mem[0] = 32'h0000_0100;
   end
   // outside an ack the data bus shows the inverse, so a stale sample shows
   assign o_rdata = o_ack ? mem[i_addr] : ~mem[i_addr];
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_ack <= 1'b0;
         cnt_q <= 4'h0;
      end else if (o_ack) begin
         o_ack <= 1'b0;
         cnt_q <= 4'h0;
         if (i_we) begin
            mem[i_addr] <= i_wdata;
         end
      end else if (i_req) begin
         if (cnt_q >= i_wait) begin
            o_ack <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end
endmodule : iosm_nvm_model
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "iosm_defines.svh"
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [24:0] src = 25'h000_0000;
   logic [3:0] nv_wait = 4'h0;
   logic ce = 1'b1;
   logic pready, pslverr, nv_req, nv_we, nv_ack;
   logic [31:0] prdata, nv_wdata, nv_rdata, rd;
   logic [17:0] dst;
   logic [3:0] od_out, od_oe_n;
   logic [5:0] nv_addr;
   logic err;
   int fail_count = 0;
   int cmp_count = 0;
   int hi;
   always #2 clk = ~clk;
   iosm_top DUT (.I_CLOCK(clk), .I_RST(rst), .I_CLK_EN(ce),
      .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
      .O_PRDATA(prdata), .O_PSLVERR(pslverr), .I_SRC_EXT(src),
      .O_DST(dst), .O_OD_OUT(od_out), .O_OD_OE_N(od_oe_n),
      .O_NVM_REQ(nv_req), .O_NVM_WE(nv_we), .O_NVM_ADDR(nv_addr),
      .O_NVM_WDATA(nv_wdata), .I_NVM_ACK(nv_ack), .I_NVM_RDATA(nv_rdata));
   iosm_nvm_model NVM (.i_clk(clk), .i_rst(rst), .i_req(nv_req),
      .i_we(nv_we), .i_addr(nv_addr), .i_wdata(nv_wdata), .i_wait(nv_wait),
      .o_ack(nv_ack), .o_rdata(nv_rdata));
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fail_count++;
         conclude();
      end
   endtask : apb
   task automatic wait_idle();
      int n;
      n = 0;
      while (nv_req !== 1'b0 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (nv_req !== 1'b0) begin
         fail_count++;
         conclude();
      end
      repeat (3) @(posedge clk);
   endtask : wait_idle
   function automatic logic lop(input int op, input logic a, b);
      case (op)
         0: return a & b;
         1: return a | b;
         2: return a ^ b;
         default: return ~(a ^ b);
      endcase
   endfunction : lop
   task automatic count_hi(input int cyc);
      hi = 0;
      repeat (cyc) begin
         @(posedge clk);
         if (dst[6] === 1'b1) hi++;
      end
   endtask : count_hi
   logic [1:0] fm [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
   logic fexp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk("oe_n in load", od_oe_n, 4'hF);
      chk("req in load", nv_req, 1'b1);
      wait_idle();
      src <= 25'h000_0000;
      repeat (3) @(posedge clk);
      chk("loaded dst0", dst[0], 1'b0);
      chk("oe_n sinks", od_oe_n[0], 1'b0);
      chk("od data", od_out, 4'h0);
      apb(1'b1, 12'h004, 32'h0000_0102);
      src <= 25'h000_0004;
      repeat (3) @(posedge clk);
      chk("route dst1", dst[1], 1'b1);
      chk("no select", dst[4], 1'b0);
      nv_wait <= 4'h3;
      apb(1'b1, `IOSM_OFF_CTRL, 32'h0000_0001);
      apb(1'b1, 12'h008, 32'h0000_0101);
      chk("busy write", err, 1'b1);
      wait_idle();
      chk("saved word", NVM.mem[1], 32'h0000_0102);
      src <= 25'h000_0000;
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, 12'h004, {21'h0, fm[m], 9'h102});
         repeat (3) @(posedge clk);
         chk("inv force", dst[1], fexp[m]);
      end
      apb(1'b1, 12'h028, 32'h0000_0100);
      apb(1'b1, 12'h02C, 32'h0000_0101);
      apb(1'b1, 12'h014, 32'h0000_0113);
      for (int op = 0; op < 4; op++) begin
         apb(1'b1, 12'h050, op);
         for (int ab = 0; ab < 4; ab++) begin
            src <= 25'(ab);
            repeat (6) @(posedge clk);
            chk("logic out", dst[5], lop(op, ab[0], ab[1]));
         end
      end
      src <= 25'h000_0000;
      apb(1'b1, 12'h018, 32'h0000_0106);
      apb(1'b1, 12'h034, 32'h0000_0103);
      apb(1'b1, 12'h058, 32'h0000_0002);
      apb(1'b1, 12'h05C, 32'h0000_0002);
      apb(1'b1, 12'h054, 32'h0001_0003);
      apb(1'b1, `IOSM_OFF_CTRL, 32'h0000_0010);
      count_hi(80);
      chk("sw pulse", hi >= 6 && hi <= 9, 1'b1);
      apb(1'b1, 12'h054, 32'h0002_0001);
      src <= 25'h000_0008;
      count_hi(120);
      chk("hw pulse", hi >= 12 && hi <= 18, 1'b1);
      apb(1'b1, 12'h050, 32'h0004_0004);
      apb(1'b1, 12'h024, 32'h0000_0100);
      apb(1'b1, 12'h008, 32'h0000_0111);
      apb(1'b1, 12'h020, 32'h0000_0101);
      apb(1'b1, 12'h00C, 32'h0000_0110);
      // four 4-cycle pulses on source 0; only the 1st and 3rd pass
      hi = 0;
      for (int p = 0; p < 32; p++) begin
         src <= 25'(p[2]);
         @(posedge clk);
         if (dst[2] === 1'b1) hi++;
      end
      chk("prescale", hi, 8);
      src <= 25'h000_0002;
      repeat (3) @(posedge clk);
      src <= 25'h000_0000;
      repeat (20) @(posedge clk);
      chk("glitch held", dst[3], 1'b0);
      src <= 25'h000_0002;
      repeat (40) @(posedge clk);
      chk("debounced", dst[3], 1'b1);
      apb(1'b1, 12'h01C, 32'h0000_0108);
      src <= 25'h000_0140;
      repeat (3) @(posedge clk);
      chk("seq trigger", dst[7], 1'b1);
      chk("internal src", dst[6], 1'b0);
      ce <= 1'b0;
      src <= 25'h000_0000;
      repeat (4) @(posedge clk);
      chk("frozen", dst[7], 1'b1);
      ce <= 1'b1;
      repeat (3) @(posedge clk);
      chk("thawed", dst[7], 1'b0);
      apb(1'b1, 12'h048, 32'h0000_0100);
      repeat (3) @(posedge clk);
      chk("src invert", dst[7], 1'b1);
      src <= 25'h000_0000;
      apb(1'b1, `IOSM_OFF_CTRL, 32'h0000_0002);
      for (int n = 0; n < 200; n++) begin
         apb(1'b0, `IOSM_OFF_STAT, 32'h0);
         if (rd[0] === 1'b0) break;
      end
      chk("restore idle", rd[0], 1'b0);
      apb(1'b0, 12'h004, 32'h0);
      chk("restored", rd, `IOSM_CFG_RST);
      apb(1'b0, 12'h0FC, 32'h0);
      chk("unmapped", err, 1'b1);
      apb(1'b1, `IOSM_OFF_STAT, 32'h0);
      chk("status ro", err, 1'b1);
      conclude();
   end
endmodule : tb_top
`default_nettype wire
